// ===== shared/sample_buffer_defines.vh
`ifndef SAMPLE_BUFFER_DEFINES_VH
`define SAMPLE_BUFFER_DEFINES_VH

// ----------------------------------------------------------------------------
// Register addresses.
// ----------------------------------------------------------------------------
`define ADDR_STATE 8'h0b
`define ADDR_X_FIRST 8'h0c
`define ADDR_X_SECOND 8'h0d
`define ADDR_Y_FIRST 8'h0e
`define ADDR_Y_SECOND 8'h0f
`define ADDR_Z_FIRST 8'h10
`define ADDR_Z_SECOND 8'h11

// ----------------------------------------------------------------------------
// Buffer geometry and field layout.
// ----------------------------------------------------------------------------
`define BUF_DEPTH 6'h20
`define PTR_W 5
`define SAMPLE_W 36
`define AXIS_W 12
`define CNT_W 6
`define MODE_OFF 2'h0
`define STATE_WMRK_BIT 7
`define STATE_OVF_BIT 6
`define X_LO 0
`define Y_LO 12
`define Z_LO 24
`define SIGN_BIT 11

`endif

// ===== rtl/sample_memory.v
`timescale 1ns/1ps
`include "sample_buffer_defines.vh"

// ----------------------------------------------------------------------------
// Sample store with registered read data.
// ----------------------------------------------------------------------------
module sample_memory (
  // Clock.
  input wire clk_sys_i,
  // Write port.
  input wire wr_en_i,
  input wire [`PTR_W-1:0] wr_addr_i,
  input wire [`SAMPLE_W-1:0] wr_data_i,
  // Read port.
  input wire [`PTR_W-1:0] rd_addr_i,
  output reg [`SAMPLE_W-1:0] rd_data_o
);
  reg [`SAMPLE_W-1:0] mem [0:`BUF_DEPTH-1];

  always @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ===== rtl/axis_byte_formatter.v
`timescale 1ns/1ps
`include "sample_buffer_defines.vh"

// ----------------------------------------------------------------------------
// Formats one 12-bit axis into its first and second register bytes.
// ----------------------------------------------------------------------------
module axis_byte_formatter (
  // Sample and format controls.
  input wire [`AXIS_W-1:0] axis_i,
  input wire byte_order_select_i,
  input wire fast_read_i,
  // Register bytes.
  output wire [7:0] first_byte_o,
  output wire [7:0] second_byte_o
);
  wire sign_copy_bits;

  assign sign_copy_bits = axis_i[`SIGN_BIT];
  // Fast read or big-endian put bits 11:4 first; else bits 7:0.
  assign first_byte_o = (fast_read_i | byte_order_select_i) ?
    axis_i[11:4] : axis_i[7:0];
  // Big-endian leaves the low nibble zero; little-endian copies the sign.
  assign second_byte_o = byte_order_select_i ?
    {axis_i[3:0], 4'h0} :
    {{4{sign_copy_bits}}, axis_i[11:8]};
endmodule

// ===== rtl/accel_sample_buffer_readout.v
`timescale 1ns/1ps
`include "sample_buffer_defines.vh"

// Behaviour
// - Count field bits 5:0 holds stored triplets, 0 to 32.
// - A triplet arriving when full keeps count 32 and sets overflow.
// - Reading one whole sample out clears the overflow flag.
// - A flush request clears the overflow flag.
// - Mode 00b clears overflow and count, keeps stored contents.
// - Readout order bit picks oldest (FIFO) or newest (LIFO) sample.
// - Each axis sample is a 12-bit two's complement value.
// - Byte order select picks layout; little-endian after reset.
// - Little-endian: bits 7:0 first, bits 11:8 low nibble next.
// - Little-endian second byte upper nibble copies the sign bit.
// - Big-endian: bits 11:4 first, bits 3:0 high nibble next.
// - Big-endian second byte low nibble always reads zero.
// - Fast read makes auto-increment skip second bytes.
// - Fast read puts bits 11:4 at the first byte address.
// - Axis skip bits make auto-increment pass over that axis.
// - Watermark flag clears without reading the status register.
// - Axis pairs sit at 0Ch/0Dh, 0Eh/0Fh, 10h/11h.
// - Watermark flag is set while count reaches the watermark level.
module accel_sample_buffer_readout (
  // Clock and reset.
  input wire clk_sys_i,
  input wire resetn_i,
  // Sample write side.
  input wire sample_valid_i,
  input wire [`SAMPLE_W-1:0] sample_data_i,
  // Configuration.
  input wire [1:0] buffer_mode_i,
  input wire readout_lifo_i,
  input wire byte_order_select_i,
  input wire fast_read_i,
  input wire axis_x_skip_i,
  input wire axis_y_skip_i,
  input wire axis_z_skip_i,
  input wire [`CNT_W-1:0] watermark_level_i,
  input wire flush_i,
  // Register read port.
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  output reg [7:0] rd_data_o,
  output reg [7:0] next_addr_o,
  // Status.
  output reg [`CNT_W-1:0] stored_sample_count_o,
  output reg overflow_flag_o,
  output reg watermark_flag_o
);
  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  reg [`PTR_W-1:0] wr_ptr_ff;
  reg [`PTR_W-1:0] rd_ptr_ff;
  reg [`CNT_W-1:0] count_ff;
  reg overflow_ff;
  reg [`CNT_W-1:0] nxt_count;
  reg nxt_overflow;
  reg [`PTR_W-1:0] nxt_wr_ptr;
  reg [`PTR_W-1:0] nxt_rd_ptr;
  reg [7:0] nxt_rd_data;
  reg [7:0] nxt_addr;
  reg [7:0] last_addr;
  wire [`SAMPLE_W-1:0] mem_rd_data;
  wire [`PTR_W-1:0] mem_rd_addr;
  wire [7:0] x_first;
  wire [7:0] x_second;
  wire [7:0] y_first;
  wire [7:0] y_second;
  wire [7:0] z_first;
  wire [7:0] z_second;
  wire buf_on;
  wire full;
  wire do_write;
  wire sample_done;
  wire [7:0] status_byte;

  // --------------------------------------------------------------------------
  // Storage and formatting.
  // --------------------------------------------------------------------------
  assign buf_on = (buffer_mode_i != `MODE_OFF);
  assign full = (count_ff == `BUF_DEPTH);
  assign do_write = sample_valid_i & buf_on;

  // LIFO reads the newest entry, FIFO the oldest.
  assign mem_rd_addr = readout_lifo_i ?
    (wr_ptr_ff - {{(`PTR_W-1){1'b0}}, 1'b1}) : rd_ptr_ff;

  sample_memory u_mem (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(do_write),
    .wr_addr_i(wr_ptr_ff),
    .wr_data_i(sample_data_i),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(mem_rd_data)
  );

  // Each axis is a 12-bit two's complement field of the sample.
  axis_byte_formatter u_fmt_x (
    .axis_i(mem_rd_data[`X_LO+`AXIS_W-1:`X_LO]),
    .byte_order_select_i(byte_order_select_i),
    .fast_read_i(fast_read_i),
    .first_byte_o(x_first),
    .second_byte_o(x_second)
  );

  axis_byte_formatter u_fmt_y (
    .axis_i(mem_rd_data[`Y_LO+`AXIS_W-1:`Y_LO]),
    .byte_order_select_i(byte_order_select_i),
    .fast_read_i(fast_read_i),
    .first_byte_o(y_first),
    .second_byte_o(y_second)
  );

  axis_byte_formatter u_fmt_z (
    .axis_i(mem_rd_data[`Z_LO+`AXIS_W-1:`Z_LO]),
    .byte_order_select_i(byte_order_select_i),
    .fast_read_i(fast_read_i),
    .first_byte_o(z_first),
    .second_byte_o(z_second)
  );

  // --------------------------------------------------------------------------
  // Last enabled byte of a triplet.
  // --------------------------------------------------------------------------
  always @* begin
    last_addr = `ADDR_STATE;
    if (!axis_z_skip_i) begin
      last_addr = fast_read_i ? `ADDR_Z_FIRST : `ADDR_Z_SECOND;
    end else if (!axis_y_skip_i) begin
      last_addr = fast_read_i ? `ADDR_Y_FIRST : `ADDR_Y_SECOND;
    end else if (!axis_x_skip_i) begin
      last_addr = fast_read_i ? `ADDR_X_FIRST : `ADDR_X_SECOND;
    end
  end

  assign sample_done = rd_en_i & (rd_addr_i == last_addr) &
    (count_ff != {`CNT_W{1'b0}}) & !axis_all_skipped(axis_x_skip_i,
    axis_y_skip_i, axis_z_skip_i);

  function axis_all_skipped;
    input xs;
    input ys;
    input zs;
    begin
      axis_all_skipped = xs & ys & zs;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Auto-increment address.
  // --------------------------------------------------------------------------
  always @* begin
    nxt_addr = rd_addr_i + 8'h01;
    if (rd_addr_i == `ADDR_STATE || rd_addr_i == last_addr) begin
      if (!axis_x_skip_i) begin
        nxt_addr = `ADDR_X_FIRST;
      end else if (!axis_y_skip_i) begin
        nxt_addr = `ADDR_Y_FIRST;
      end else if (!axis_z_skip_i) begin
        nxt_addr = `ADDR_Z_FIRST;
      end else begin
        nxt_addr = `ADDR_STATE;
      end
    end else if (rd_addr_i == `ADDR_X_FIRST ||
                 rd_addr_i == `ADDR_X_SECOND) begin
      if (!fast_read_i && rd_addr_i == `ADDR_X_FIRST) begin
        nxt_addr = `ADDR_X_SECOND;
      end else if (!axis_y_skip_i) begin
        nxt_addr = `ADDR_Y_FIRST;
      end else begin
        nxt_addr = `ADDR_Z_FIRST;
      end
    end else if (rd_addr_i == `ADDR_Y_FIRST ||
                 rd_addr_i == `ADDR_Y_SECOND) begin
      if (!fast_read_i && rd_addr_i == `ADDR_Y_FIRST) begin
        nxt_addr = `ADDR_Y_SECOND;
      end else begin
        nxt_addr = `ADDR_Z_FIRST;
      end
    end else if (rd_addr_i == `ADDR_Z_FIRST) begin
      if (!fast_read_i) begin
        nxt_addr = `ADDR_Z_SECOND;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register read data.
  // --------------------------------------------------------------------------
  assign status_byte = {(count_ff >= watermark_level_i) & buf_on,
    overflow_ff, count_ff};

  always @* begin
    nxt_rd_data = 8'h00;
    if (rd_addr_i == `ADDR_STATE) begin
      nxt_rd_data = status_byte;
    end else if (rd_addr_i == `ADDR_X_FIRST) begin
      nxt_rd_data = x_first;
    end else if (rd_addr_i == `ADDR_X_SECOND) begin
      nxt_rd_data = x_second;
    end else if (rd_addr_i == `ADDR_Y_FIRST) begin
      nxt_rd_data = y_first;
    end else if (rd_addr_i == `ADDR_Y_SECOND) begin
      nxt_rd_data = y_second;
    end else if (rd_addr_i == `ADDR_Z_FIRST) begin
      nxt_rd_data = z_first;
    end else if (rd_addr_i == `ADDR_Z_SECOND) begin
      nxt_rd_data = z_second;
    end
  end

  // --------------------------------------------------------------------------
  // Pointer, count and overflow update.
  // --------------------------------------------------------------------------
  always @* begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    nxt_overflow = overflow_ff;
    if (!buf_on) begin
      nxt_count = {`CNT_W{1'b0}};
      nxt_overflow = 1'b0;
      nxt_rd_ptr = wr_ptr_ff;
    end else if (flush_i) begin
      nxt_count = {`CNT_W{1'b0}};
      nxt_overflow = 1'b0;
      nxt_rd_ptr = wr_ptr_ff;
    end else begin
      if (sample_done) begin
        nxt_overflow = 1'b0;
        if (readout_lifo_i) begin
          nxt_wr_ptr = wr_ptr_ff - {{(`PTR_W-1){1'b0}}, 1'b1};
        end else begin
          nxt_rd_ptr = rd_ptr_ff + {{(`PTR_W-1){1'b0}}, 1'b1};
        end
        nxt_count = count_ff - {{(`CNT_W-1){1'b0}}, 1'b1};
      end
      if (do_write) begin
        nxt_wr_ptr = nxt_wr_ptr + {{(`PTR_W-1){1'b0}}, 1'b1};
        if (full && !sample_done) begin
          nxt_overflow = 1'b1;
          nxt_rd_ptr = rd_ptr_ff + {{(`PTR_W-1){1'b0}}, 1'b1};
        end else begin
          nxt_count = nxt_count + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_ff <= {`PTR_W{1'b0}};
      rd_ptr_ff <= {`PTR_W{1'b0}};
      count_ff <= {`CNT_W{1'b0}};
      overflow_ff <= 1'b0;
      rd_data_o <= 8'h00;
      next_addr_o <= `ADDR_STATE;
      stored_sample_count_o <= {`CNT_W{1'b0}};
      overflow_flag_o <= 1'b0;
      watermark_flag_o <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      overflow_ff <= nxt_overflow;
      if (rd_en_i) begin
        rd_data_o <= nxt_rd_data;
        next_addr_o <= nxt_addr;
      end
      stored_sample_count_o <= nxt_count;
      overflow_flag_o <= nxt_overflow;
      watermark_flag_o <= buf_on & (nxt_count >= watermark_level_i);
    end
  end
endmodule

// ===== tb/sample_buffer_properties.sv
`timescale 1ns/1ps
`include "sample_buffer_defines.vh"

// ------
// Port checks of the readout block.
// ------
module sample_buffer_properties (
  // Clock and reset.
  input wire clk_sys_i,
  input wire resetn_i,
  // Inputs.
  input wire sample_valid_i,
  input wire [1:0] buffer_mode_i,
  input wire byte_order_select_i,
  input wire fast_read_i,
  input wire axis_x_skip_i,
  input wire axis_y_skip_i,
  input wire axis_z_skip_i,
  input wire flush_i,
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  // Outputs.
  input wire [7:0] rd_data_o,
  input wire [7:0] next_addr_o,
  input wire [`CNT_W-1:0] stored_sample_count_o,
  input wire overflow_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire on = buffer_mode_i != 2'h0;
  wire plain = !fast_read_i && !axis_x_skip_i && !axis_y_skip_i
    && !axis_z_skip_i;
  wire sec = rd_addr_i == 8'h0d || rd_addr_i == 8'h0f || rd_addr_i == 8'h11;
  chk_count_range: assert property (
    stored_sample_count_o <= 6'h20) else $error("count above 32");
  chk_full_overflow: assert property (
    stored_sample_count_o == 6'h20 && sample_valid_i && on && !flush_i
    && !rd_en_i |=> stored_sample_count_o == 6'h20 && overflow_flag_o)
    else $error("no overflow");
  chk_flush_clear: assert property (
    flush_i |=> !overflow_flag_o) else $error("flush kept overflow");
  chk_mode_off: assert property (
    !on |=> stored_sample_count_o == 6'h00 && !overflow_flag_o)
    else $error("mode off kept state");
  chk_le_sign: assert property (
    rd_en_i && !byte_order_select_i && !fast_read_i && sec
    |=> rd_data_o[7:4] == {4{rd_data_o[3]}}) else $error("bad sign copy");
  chk_be_zero: assert property (
    rd_en_i && byte_order_select_i && !fast_read_i && sec
    |=> rd_data_o[3:0] == 4'h0) else $error("low nibble not zero");
  chk_unmapped_zero: assert property (
    rd_en_i && (rd_addr_i > 8'h11 || rd_addr_i < 8'h0b)
    |=> rd_data_o == 8'h00) else $error("unmapped not zero");
  chk_fast_skip: assert property (
    rd_en_i && fast_read_i && !axis_y_skip_i && rd_addr_i == 8'h0c
    |=> next_addr_o == 8'h0e) else $error("fast read no skip");
  chk_pop_count: assert property (
    rd_en_i && plain && rd_addr_i == 8'h11 && on && !flush_i
    && stored_sample_count_o != 6'h00 && !sample_valid_i
    |=> stored_sample_count_o == $past(stored_sample_count_o) - 6'h01
    && !overflow_flag_o) else $error("bad pop");
endmodule

bind accel_sample_buffer_readout sample_buffer_properties u_props (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .sample_valid_i(sample_valid_i), .buffer_mode_i(buffer_mode_i),
  .byte_order_select_i(byte_order_select_i), .fast_read_i(fast_read_i),
  .axis_x_skip_i(axis_x_skip_i), .axis_y_skip_i(axis_y_skip_i),
  .axis_z_skip_i(axis_z_skip_i), .flush_i(flush_i), .rd_en_i(rd_en_i),
  .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .next_addr_o(next_addr_o),
  .stored_sample_count_o(stored_sample_count_o),
  .overflow_flag_o(overflow_flag_o));

// ===== tb/host_model.sv
`timescale 1ns/1ps

// ------
// Host reading the register port.
// ------
module host_model (
  // Clock.
  input wire clk_sys_i,
  // Read port.
  input wire [7:0] rd_data_i,
  output reg rd_en_o = 1'b0,
  output reg [7:0] rd_addr_o = 8'h00
);
  // One strobe cycle, data taken a cycle later.
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk_sys_i);
      rd_en_o = 1'b1;
      rd_addr_o = a;
      @(negedge clk_sys_i);
      rd_en_o = 1'b0;
      d = rd_data_i;
    end
  endtask
  // Status is read before each burst to confirm the event.
  task confirm(output [7:0] d);
    rd(8'h0b, d);
  endtask
endmodule

// ===== tb/accel_sample_buffer_readout_tb.sv
`timescale 1ns/1ps
`include "sample_buffer_defines.vh"

// ------
// Self-checking bench of the readout block.
// ------
module accel_sample_buffer_readout_tb;
  reg clk_sys_i = 1'b0;
  reg resetn_i = 1'b0;
  reg sample_valid_i = 1'b0;
  reg [35:0] sample_data_i = 36'h0;
  reg [1:0] buffer_mode_i = 2'h0;
  reg readout_lifo_i = 1'b0, bo = 1'b0, fr = 1'b0, xs = 1'b0, flush_i = 1'b0;
  wire rd_en, ovf, wmrk;
  wire [7:0] rd_addr, rd_data, next_addr;
  wire [5:0] cnt;
  integer errors = 0, checks = 0, seed = 32'hfb857515, m, i;
  reg [7:0] d, ax;
  reg [35:0] s, q1;
  always #20 clk_sys_i = ~clk_sys_i;
  accel_sample_buffer_readout uut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .sample_valid_i(sample_valid_i), .sample_data_i(sample_data_i),
    .buffer_mode_i(buffer_mode_i), .readout_lifo_i(readout_lifo_i),
    .byte_order_select_i(bo), .fast_read_i(fr), .axis_x_skip_i(xs),
    .axis_y_skip_i(1'b0), .axis_z_skip_i(1'b0), .watermark_level_i(6'h10),
    .flush_i(flush_i), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .next_addr_o(next_addr),
    .stored_sample_count_o(cnt), .overflow_flag_o(ovf),
    .watermark_flag_o(wmrk));
  host_model host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data),
    .rd_en_o(rd_en), .rd_addr_o(rd_addr));
  function [35:0] rnd(input [31:0] a, input [31:0] b);
    rnd = {a[3:0], b};
  endfunction
  function [7:0] fmt(input [11:0] a, input sc);
    if (fr) fmt = a[11:4];
    else if (bo) fmt = sc ? {a[3:0], 4'h0} : a[11:4];
    else fmt = sc ? {{4{a[11]}}, a[11:8]} : a[7:0];
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task push(input [35:0] v);
    begin
      @(negedge clk_sys_i);
      sample_valid_i = 1'b1;
      sample_data_i = v;
      @(negedge clk_sys_i);
      sample_valid_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
    end
  endtask
  task rd_sample(input [35:0] v);
    begin
      host.confirm(d);
      chk(next_addr, xs ? 8'h0e : 8'h0c);
      for (ax = {7'h0, xs}; ax < 8'h03; ax = ax + 8'h01) begin
        host.rd(8'h0c + (ax << 1), d);
        chk(d, fmt(v[12*ax +: 12], 1'b0));
        if (!fr) begin
          host.rd(8'h0d + (ax << 1), d);
          chk(d, fmt(v[12*ax +: 12], 1'b1));
        end
        chk(next_addr, ax == 8'h02 ? (xs ? 8'h0e : 8'h0c) : 8'h0e + (ax << 1));
      end
      repeat (2) @(negedge clk_sys_i);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  initial begin
    #2000000;
    errors = errors + 1;
    $display("BAD %0t run hung", $time);
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    buffer_mode_i = 2'h1;
    for (m = 0; m < 4; m = m + 1) begin
      bo = m[0];
      fr = m[1];
      xs = (m == 3);
      s = rnd($random(seed), $random(seed));
      if (m == 0) s[11:0] = 12'h800;
      if (m == 1) s[23:12] = 12'h7ff;
      push(s);
      rd_sample(s);
      chk({2'b0, cnt}, 8'h00);
    end
    bo = 1'b0;
    fr = 1'b0;
    xs = 1'b0;
    for (i = 0; i < 33; i = i + 1) begin
      s = rnd($random(seed), $random(seed));
      if (i == 1) q1 = s;
      push(s);
    end
    host.confirm(d);
    chk(d, 8'he0);
    rd_sample(q1);
    chk({wmrk, ovf, cnt}, 8'h9f);
    readout_lifo_i = 1'b1;
    s = rnd($random(seed), $random(seed));
    push(s);
    rd_sample(s);
    readout_lifo_i = 1'b0;
    push(s);
    push(s);
    chk({wmrk, ovf, cnt}, 8'he0);
    flush_i = 1'b1;
    @(negedge clk_sys_i);
    flush_i = 1'b0;
    @(negedge clk_sys_i);
    chk({6'h0, wmrk, ovf}, 8'h00);
    push(s);
    buffer_mode_i = 2'h0;
    repeat (2) @(negedge clk_sys_i);
    chk({wmrk, ovf, cnt}, 8'h00);
    buffer_mode_i = 2'h1;
    host.rd(8'h3f, d);
    chk(d, 8'h00);
    stop_test;
  end
endmodule
